// >>> hdl/prt_debounce.sv
// two-flop synchroniser and debouncer for one contact or pulse pin
`timescale 1ns/1ps
module prt_debounce
   import prt_pkg::*;
#(
   parameter int unsigned CYC = 16
)(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // pin side
   input  wire logic raw,
   // clean side
   output logic      level_ff,
   output logic      rise_ff
);

   logic        s1_ff;
   logic        s2_ff;
   logic [31:0] cnt_ff;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
      end
   end

   // level changes only after the pin stayed put for CYC cycles
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff   <= 32'h0;
         level_ff <= 1'b0;
         rise_ff  <= 1'b0;
      end
      else
      begin
         rise_ff <= 1'b0;
         if (s2_ff == level_ff)
            cnt_ff <= 32'h0;
         else if (cnt_ff >= 32'(CYC - 1))
         begin
            cnt_ff   <= 32'h0;
            level_ff <= s2_ff;
            rise_ff  <= s2_ff;
         end
         else
            cnt_ff <= cnt_ff + 32'h1;
      end
   end

   AST_ONE_EDGE: assert property (@(posedge core_clk) disable iff (!nrst)
      rise_ff |=> !rise_ff && level_ff)
      else $error("debouncer gave two edges in a row");

endmodule : prt_debounce

// >>> hdl/prt_pkg.sv
// constants, types and helpers shared by the pulse rate totaliser
package prt_pkg;

   // ---------------------------------------------------------------
   // clock and times
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
   localparam int unsigned T_PWRUP_MS    = 100;
   localparam int unsigned T_SEG_TEST_MS = 2000;
   localparam int unsigned T_ID_MS       = 2000;
   localparam int unsigned T_LOC_RST_MS  = 2000;
   localparam int unsigned T_REM_RST_MS  = 1000;
   localparam int unsigned T_FLOW_MS     = 2000;
   localparam int unsigned T_GATE_MS     = 1000;
   localparam int unsigned T_DB_BTN_MS   = 10;
   localparam int unsigned T_DB_PULSE_US = 20;
   localparam int unsigned PWRUP_CYC     = T_PWRUP_MS * CYC_PER_MS;
   localparam int unsigned SEG_TEST_CYC  = T_SEG_TEST_MS * CYC_PER_MS;
   localparam int unsigned ID_CYC        = T_ID_MS * CYC_PER_MS;
   localparam int unsigned LOC_RST_CYC   = T_LOC_RST_MS * CYC_PER_MS;
   localparam int unsigned REM_RST_CYC   = T_REM_RST_MS * CYC_PER_MS;
   localparam int unsigned FLOW_CYC      = T_FLOW_MS * CYC_PER_MS;
   localparam int unsigned GATE_CYC      = T_GATE_MS * CYC_PER_MS;
   localparam int unsigned DB_BTN_CYC    = T_DB_BTN_MS * CYC_PER_MS;
   localparam int unsigned DB_PULSE_CYC  = T_DB_PULSE_US * CYC_PER_US;

   // ---------------------------------------------------------------
   // display layout
   // ---------------------------------------------------------------
   localparam int unsigned RATE_DIGITS  = 6;
   localparam int unsigned TOTAL_DIGITS = 8;
   localparam int unsigned GRAND_DIGITS = 16;
   localparam logic [3:0]  DIGIT_ALL_ON = 4'h8;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_WAIT = 4'b0001,
      ST_TEST = 4'b0010,
      ST_ID   = 4'b0100,
      ST_RUN  = 4'b1000
   } prt_state_t;

   typedef struct packed {
      logic prog;
      logic enter;
      logic up;
      logic down;
   } prt_btn_t;

   typedef struct packed {
      logic        loc_rst_en;
      logic [15:0] tot_div;
      logic [15:0] rate_div;
      logic [15:0] clip_min;
   } prt_cal_t;

   typedef struct packed {
      logic                        all_on;
      logic [RATE_DIGITS*4-1:0]    rate;
      logic [TOTAL_DIGITS*4-1:0]   total;
      logic                        ann_grand;
      logic                        ann_hold;
      logic                        ann_reset;
      logic                        flow_spin;
   } prt_disp_t;

   // ---------------------------------------------------------------
   // bcd increment by one, wraps at all nines
   // ---------------------------------------------------------------
   function automatic logic [GRAND_DIGITS*4-1:0] prt_bcd_inc(input logic [GRAND_DIGITS*4-1:0] v);
      logic [GRAND_DIGITS*4-1:0] r;
      logic                      c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < GRAND_DIGITS; i++)
      begin
         if (c)
         begin
            if (r[i*4 +: 4] == 4'h9)
               r[i*4 +: 4] = 4'h0;
            else
            begin
               r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction : prt_bcd_inc

endpackage : prt_pkg

// >>> hdl/prt_totaliser.sv
// pulse rate totaliser: start-up, counting, buttons and display drive
//
// How it works
// - all segments lit two seconds after delay
// - then firmware identity shown two seconds
// - then run with calibration latched from storage
// - enter plus down shows grand total low
// - enter plus up shows grand total high
// - down plus up two seconds clears total
// - down alone shows firmware identity
// - scaled rate on six digit display
// - scaled total on eight digit display
// - remote contact or buttons clear the total
// - flow indicator spins two seconds per pulse
// - hold lit below clip-off frequency
// - reset annunciator lit during reset
// - one pulse source feeds rate and total
// - remote contact over one second clears total
// - held remote contact inhibits totalisation
`timescale 1ns/1ps
module prt_totaliser
   import prt_pkg::*;
#(
   parameter int unsigned          PWRUP_N    = PWRUP_CYC,
   parameter int unsigned          TEST_N     = SEG_TEST_CYC,
   parameter int unsigned          ID_N       = ID_CYC,
   parameter int unsigned          LOC_RST_N  = LOC_RST_CYC,
   parameter int unsigned          REM_RST_N  = REM_RST_CYC,
   parameter int unsigned          FLOW_N     = FLOW_CYC,
   parameter int unsigned          GATE_N     = GATE_CYC,
   parameter int unsigned          DB_BTN_N   = DB_BTN_CYC,
   parameter int unsigned          DB_PULSE_N = DB_PULSE_CYC,
   // arbitrary identity values
   parameter logic [RATE_DIGITS*4-1:0]  FW_PART = 24'h000123,
   parameter logic [TOTAL_DIGITS*4-1:0] FW_VER  = 32'h00000101
)(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // field pins
   input  wire logic pulse_pin,
   input  wire logic rem_rst_pin,
   input  wire prt_btn_t btn_pin,
   // calibration from non-volatile storage
   input  wire prt_cal_t cal_nv,
   // display drive
   output prt_disp_t disp_ff
);

   // ---------------------------------------------------------------
   // input conditioning
   // ---------------------------------------------------------------
   logic       pulse_evt;
   logic [4:0] slow_raw;
   logic [4:0] slow_lvl;

   assign slow_raw = {rem_rst_pin, btn_pin};

   prt_debounce #(.CYC(DB_PULSE_N)) u_pulse (
      .core_clk (core_clk),
      .nrst     (nrst),
      .raw      (pulse_pin),
      .level_ff (),
      .rise_ff  (pulse_evt)
   );

   for (genvar g = 0; g < 5; g++)
   begin : g_slow
      prt_debounce #(.CYC(DB_BTN_N)) u_db (
         .core_clk (core_clk),
         .nrst     (nrst),
         .raw      (slow_raw[g]),
         .level_ff (slow_lvl[g]),
         .rise_ff  ()
      );
   end

   logic rem_on;
   logic b_enter;
   logic b_up;
   logic b_down;
   logic show_lo;
   logic show_hi;
   logic show_id;
   logic ud_held;

   assign rem_on  = slow_lvl[4];
   assign b_enter = slow_lvl[2];
   assign b_up    = slow_lvl[1];
   assign b_down  = slow_lvl[0];
   assign show_lo = b_enter && b_down && !b_up;
   assign show_hi = b_enter && b_up && !b_down;
   assign show_id = b_down && !b_enter && !b_up;
   assign ud_held = b_up && b_down && !b_enter;

   // ---------------------------------------------------------------
   // start-up sequence
   // ---------------------------------------------------------------
   prt_state_t  st_ff;
   logic [31:0] tmr_ff;
   prt_cal_t    cal_ff;
   logic        run;

   assign run = (st_ff == ST_RUN);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_ff  <= ST_WAIT;
         tmr_ff <= 32'h0;
      end
      else
      begin
         tmr_ff <= tmr_ff + 32'h1;
         case (st_ff)
            ST_WAIT:
               if (tmr_ff >= 32'(PWRUP_N - 1))
               begin
                  st_ff  <= ST_TEST;
                  tmr_ff <= 32'h0;
               end
            ST_TEST:
               if (tmr_ff >= 32'(TEST_N - 1))
               begin
                  st_ff  <= ST_ID;
                  tmr_ff <= 32'h0;
               end
            ST_ID:
               if (tmr_ff >= 32'(ID_N - 1))
               begin
                  st_ff  <= ST_RUN;
                  tmr_ff <= 32'h0;
               end
            ST_RUN:
               tmr_ff <= 32'h0;
            default:
            begin
               st_ff  <= ST_WAIT;
               tmr_ff <= 32'h0;
            end
         endcase
      end
   end

   // calibration is taken once, as the run phase begins
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         cal_ff <= '0;
      else if (st_ff == ST_ID && tmr_ff >= 32'(ID_N - 1))
         cal_ff <= cal_nv;
   end

   // ---------------------------------------------------------------
   // reset requests
   // ---------------------------------------------------------------
   logic [31:0] rem_cnt_ff;
   logic [31:0] loc_cnt_ff;
   logic        rem_act;
   logic        loc_act;
   logic        clr;

   assign rem_act = (rem_cnt_ff >= 32'(REM_RST_N));
   assign loc_act = (loc_cnt_ff >= 32'(LOC_RST_N));
   assign clr     = rem_act || loc_act;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rem_cnt_ff <= 32'h0;
         loc_cnt_ff <= 32'h0;
      end
      else
      begin
         if (!rem_on || !run)
            rem_cnt_ff <= 32'h0;
         else if (!rem_act)
            rem_cnt_ff <= rem_cnt_ff + 32'h1;
         if (!ud_held || !run || !cal_ff.loc_rst_en)
            loc_cnt_ff <= 32'h0;
         else if (!loc_act)
            loc_cnt_ff <= loc_cnt_ff + 32'h1;
      end
   end

   // ---------------------------------------------------------------
   // totalisation from the single pulse source
   // ---------------------------------------------------------------
   logic [15:0]                  tot_pre_ff;
   logic [TOTAL_DIGITS*4-1:0]    tot_ff;
   logic [GRAND_DIGITS*4-1:0]    grand_ff;
   logic                         tot_step;
   logic [GRAND_DIGITS*4-1:0]    tot_inc;

   assign tot_step = run && !rem_act && pulse_evt &&
                     (tot_pre_ff + 16'h1 >= cal_ff.tot_div);
   assign tot_inc  = prt_bcd_inc({32'h0, tot_ff});

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tot_pre_ff <= 16'h0;
         tot_ff     <= '0;
         grand_ff   <= '0;
      end
      else
      begin
         if (run && !rem_act && pulse_evt)
            tot_pre_ff <= tot_step ? 16'h0 : tot_pre_ff + 16'h1;
         if (tot_step)
            grand_ff <= prt_bcd_inc(grand_ff);
         if (clr)
            tot_ff <= '0;
         else if (tot_step)
            tot_ff <= tot_inc[TOTAL_DIGITS*4-1:0];
      end
   end

   // ---------------------------------------------------------------
   // rate over a gate window, from the same source
   // ---------------------------------------------------------------
   logic [31:0]                gate_ff;
   logic [15:0]                rate_pre_ff;
   logic [RATE_DIGITS*4-1:0]   rate_acc_ff;
   logic [RATE_DIGITS*4-1:0]   rate_ff;
   logic [15:0]                frq_acc_ff;
   logic [15:0]                frq_ff;
   logic                       gate_end;
   logic                       rate_step;
   logic [GRAND_DIGITS*4-1:0]  rate_inc;

   assign gate_end  = run && (gate_ff >= 32'(GATE_N - 1));
   assign rate_step = run && pulse_evt && (rate_pre_ff + 16'h1 >= cal_ff.rate_div);
   assign rate_inc  = prt_bcd_inc({40'h0, rate_acc_ff});

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         gate_ff     <= 32'h0;
         rate_pre_ff <= 16'h0;
         rate_acc_ff <= '0;
         rate_ff     <= '0;
         frq_acc_ff  <= 16'h0;
         frq_ff      <= 16'h0;
      end
      else if (run)
      begin
         if (pulse_evt)
            rate_pre_ff <= rate_step ? 16'h0 : rate_pre_ff + 16'h1;
         if (gate_end)
         begin
            gate_ff     <= 32'h0;
            rate_ff     <= rate_acc_ff;
            frq_ff      <= frq_acc_ff;
            rate_acc_ff <= '0;
            frq_acc_ff  <= {15'h0, pulse_evt};
         end
         else
         begin
            gate_ff <= gate_ff + 32'h1;
            if (rate_step)
               rate_acc_ff <= rate_inc[RATE_DIGITS*4-1:0];
            if (pulse_evt && frq_acc_ff != 16'hffff)
               frq_acc_ff <= frq_acc_ff + 16'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // flow indicator
   // ---------------------------------------------------------------
   logic [31:0] flow_ff;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         flow_ff <= 32'h0;
      else if (run && pulse_evt)
         flow_ff <= 32'(FLOW_N);
      else if (flow_ff != 32'h0)
         flow_ff <= flow_ff - 32'h1;
   end

   // ---------------------------------------------------------------
   // display drive
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         disp_ff <= '0;
      else
      begin
         disp_ff <= '0;
         case (st_ff)
            ST_WAIT:
               disp_ff <= '0;
            ST_TEST:
            begin
               disp_ff.all_on    <= 1'b1;
               disp_ff.rate      <= {RATE_DIGITS{DIGIT_ALL_ON}};
               disp_ff.total     <= {TOTAL_DIGITS{DIGIT_ALL_ON}};
               disp_ff.ann_grand <= 1'b1;
               disp_ff.ann_hold  <= 1'b1;
               disp_ff.ann_reset <= 1'b1;
               disp_ff.flow_spin <= 1'b1;
            end
            ST_ID:
            begin
               disp_ff.rate  <= FW_PART;
               disp_ff.total <= FW_VER;
            end
            ST_RUN:
            begin
               disp_ff.ann_hold  <= (frq_ff < cal_ff.clip_min);
               disp_ff.ann_reset <= clr;
               disp_ff.flow_spin <= (flow_ff != 32'h0);
               if (show_id)
               begin
                  disp_ff.rate  <= FW_PART;
                  disp_ff.total <= FW_VER;
               end
               else
               begin
                  disp_ff.rate <= rate_ff;
                  if (show_lo)
                  begin
                     disp_ff.total     <= grand_ff[31:0];
                     disp_ff.ann_grand <= 1'b1;
                  end
                  else if (show_hi)
                  begin
                     disp_ff.total     <= grand_ff[63:32];
                     disp_ff.ann_grand <= 1'b1;
                  end
                  else
                     disp_ff.total <= tot_ff;
               end
            end
            default:
               disp_ff <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_TEST_TO_ID: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_ff == ST_TEST && tmr_ff == 32'(TEST_N - 1)) |=> st_ff == ST_ID ##1 !disp_ff.all_on)
      else $error("segment test did not end on time");
   AST_ID_SHOWN: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_ff == ST_ID) |=> disp_ff.rate == FW_PART && disp_ff.total == FW_VER)
      else $error("identity not shown after test");
   AST_CAL_LOAD: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && $past(st_ff) == ST_ID) |-> cal_ff == $past(cal_nv))
      else $error("calibration not taken at run start");
   AST_GRAND_LO: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && show_lo) |=> disp_ff.ann_grand && disp_ff.total == $past(grand_ff[31:0]))
      else $error("grand total low digits not shown");
   AST_GRAND_HI: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && show_hi) |=> disp_ff.ann_grand && disp_ff.total == $past(grand_ff[63:32]))
      else $error("grand total high digits not shown");
   AST_LOC_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && ud_held && cal_ff.loc_rst_en && loc_cnt_ff == 32'(LOC_RST_N - 1)) |=> ##1 tot_ff == '0)
      else $error("local reset did not clear total");
   AST_ID_VIEW: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && show_id) |=> disp_ff.total == FW_VER && !disp_ff.ann_grand)
      else $error("identity view missing");
   AST_REM_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      (rem_act) |=> tot_ff == '0 && disp_ff.ann_reset)
      else $error("remote reset did not clear total");
   AST_INHIBIT: assert property (@(posedge core_clk) disable iff (!nrst)
      (rem_act && rem_on) |=> $stable(grand_ff))
      else $error("counting not inhibited by held contact");
   AST_FLOW: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && pulse_evt) |=> flow_ff == 32'(FLOW_N) ##1 disp_ff.flow_spin)
      else $error("flow indicator not restarted");
   AST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
      (run && frq_ff < cal_ff.clip_min) |=> disp_ff.ann_hold)
      else $error("hold annunciator missing");

endmodule : prt_totaliser

// >>> test/prt_field.sv
// flowmeter and remote contact model driving the totaliser field pins
`timescale 1ns/1ps
module prt_field
(
   // clock
   input  wire logic core_clk,
   // field pins
   output logic      pulse_pin,
   output logic      rem_rst_pin
);
   initial
   begin
      pulse_pin   = 1'b0;
      rem_rst_pin = 1'b0;
   end

   // n pulses, high and low each held half cycles, well above the filter
   task automatic send(input int n, input int half);
      repeat (n)
      begin
         @(posedge core_clk);
         pulse_pin <= 1'b1;
         repeat (half) @(posedge core_clk);
         pulse_pin <= 1'b0;
         repeat (half - 1) @(posedge core_clk);
      end
      // step off the edge so callers see settled outputs
      #1;
   endtask : send

   // contact closed while v is high
   task automatic contact(input logic v);
      @(posedge core_clk);
      rem_rst_pin <= v;
   endtask : contact
endmodule : prt_field

// >>> test/prt_totaliser_tb.sv
// self-checking bench for the pulse rate totaliser
`timescale 1ns/1ps
module prt_totaliser_tb
   import prt_pkg::*;
;
   localparam int unsigned TEST_N = 20;
   localparam int unsigned ID_N   = 20;
   localparam int unsigned FLOW_N = 40;
   localparam int unsigned PWR_N  = 10;
   localparam int unsigned RST_N  = 30;
   localparam int unsigned GATE_N = 50;
   localparam int unsigned DBB_N  = 3;
   localparam int unsigned DBP_N  = 2;
   localparam logic [23:0] PART   = 24'h000456;   // arbitrary value
   localparam logic [31:0] VER    = 32'h00000203; // arbitrary value
   logic      core_clk;
   logic      nrst;
   prt_btn_t  btn_pin;
   prt_cal_t  cal_nv;
   prt_disp_t disp_ff;
   wire logic pulse_pin;
   wire logic rem_rst_pin;
   int        n_mismatch;
   int        num_checks;
   int        cyc;

   prt_totaliser #(.PWRUP_N(PWR_N), .TEST_N(TEST_N), .ID_N(ID_N), .LOC_RST_N(RST_N), .REM_RST_N(RST_N),
      .FLOW_N(FLOW_N), .GATE_N(GATE_N), .DB_BTN_N(DBB_N), .DB_PULSE_N(DBP_N), .FW_PART(PART), .FW_VER(VER))
   dut_u (.core_clk(core_clk), .nrst(nrst), .pulse_pin(pulse_pin), .rem_rst_pin(rem_rst_pin),
      .btn_pin(btn_pin), .cal_nv(cal_nv), .disp_ff(disp_ff));
   prt_field fm_u (.core_clk(core_clk), .pulse_pin(pulse_pin), .rem_rst_pin(rem_rst_pin));

   always #5 core_clk = ~core_clk;

   // hang guard
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic push(input logic [3:0] b, input int n);
      @(posedge core_clk);
      btn_pin <= prt_btn_t'(b);
      tick(n);
   endtask : push

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_startup;
      int n;
      n = 0;
      while (disp_ff.all_on !== 1'b1 && n < 200)
      begin
         tick(1);
         n++;
      end
      chk(disp_ff.rate, 24'h888888);
      chk(disp_ff.total, 32'h88888888);
      n = 0;
      while (disp_ff.all_on === 1'b1 && n < 200)
      begin
         tick(1);
         n++;
      end
      chk(n, TEST_N);
      chk(disp_ff.rate, PART);
      n = 0;
      while (disp_ff.total === VER && n < 200)
      begin
         tick(1);
         n++;
      end
      chk(n, ID_N);
      chk(disp_ff.total, 32'h0);
      $display("test startup done");
   endtask : t_startup

   task automatic t_rate;
      tick(120);
      chk(disp_ff.ann_hold, 1'b1);
      fm_u.send(10, 6);
      chk(disp_ff.rate == 24'h4 || disp_ff.rate == 24'h5, 1'b1);
      chk(disp_ff.ann_hold, 1'b0);
      tick(120);
      chk(disp_ff.rate, 24'h0);
      chk(disp_ff.ann_hold, 1'b1);
      chk(disp_ff.total, 32'h10);
      $display("test rate done");
   endtask : t_rate

   task automatic t_flow;
      fm_u.send(1, 6);
      tick(25);
      fm_u.send(1, 6);
      tick(30);
      chk(disp_ff.flow_spin, 1'b1);
      chk(disp_ff.total, 32'h12);
      tick(FLOW_N);
      chk(disp_ff.flow_spin, 1'b0);
      $display("test flow done");
   endtask : t_flow

   task automatic t_buttons;
      push(4'h5, 12);
      chk(disp_ff.total, 32'h12);
      chk(disp_ff.ann_grand, 1'b1);
      push(4'h6, 12);
      chk(disp_ff.total, 32'h0);
      chk(disp_ff.ann_grand, 1'b1);
      push(4'h1, 12);
      chk(disp_ff.rate, PART);
      chk(disp_ff.total, VER);
      push(4'h3, 15);
      chk(disp_ff.total, 32'h12);
      tick(30);
      chk(disp_ff.total, 32'h0);
      chk(disp_ff.ann_reset, 1'b1);
      push(4'h0, 12);
      chk(disp_ff.ann_reset, 1'b0);
      push(4'h5, 12);
      chk(disp_ff.total, 32'h12);
      push(4'h0, 12);
      chk(disp_ff.ann_grand, 1'b0);
      $display("test buttons done");
   endtask : t_buttons

   task automatic t_remote;
      fm_u.send(2, 6);
      fm_u.contact(1'b1);
      tick(10);
      fm_u.contact(1'b0);
      tick(12);
      chk(disp_ff.total, 32'h2);
      fm_u.contact(1'b1);
      tick(45);
      chk(disp_ff.total, 32'h0);
      chk(disp_ff.ann_reset, 1'b1);
      fm_u.send(2, 6);
      tick(10);
      chk(disp_ff.total, 32'h0);
      fm_u.contact(1'b0);
      tick(12);
      chk(disp_ff.ann_reset, 1'b0);
      fm_u.send(1, 6);
      tick(10);
      chk(disp_ff.total, 32'h1);
      push(4'h5, 12);
      chk(disp_ff.total, 32'h15);
      push(4'h0, 12);
      $display("test remote done");
   endtask : t_remote

   // new calibration only takes effect after a restart
   task automatic t_recal;
      @(posedge core_clk);
      cal_nv <= '{loc_rst_en: 1'b0, tot_div: 16'h2, rate_div: 16'h1, clip_min: 16'h2};
      nrst   <= 1'b0;
      tick(5);
      chk(disp_ff.total, 32'h0);
      @(posedge core_clk);
      nrst <= 1'b1;
      t_startup();
      fm_u.send(3, 6);
      tick(10);
      chk(disp_ff.total, 32'h1);
      fm_u.send(1, 6);
      tick(10);
      chk(disp_ff.total, 32'h2);
      push(4'h3, 45);
      chk(disp_ff.total, 32'h2);
      chk(disp_ff.ann_reset, 1'b0);
      push(4'h0, 12);
      $display("test recal done");
   endtask : t_recal

   initial
   begin
      core_clk   = 1'b0;
      nrst       = 1'b0;
      btn_pin    = prt_btn_t'(4'h0);
      cal_nv     = '{loc_rst_en: 1'b1, tot_div: 16'h1, rate_div: 16'h1, clip_min: 16'h2};
      n_mismatch = 0;
      num_checks = 0;
      cyc        = 0;
      tick(3);
      chk(disp_ff.total, 32'h0);
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      t_startup();
      t_rate();
      t_flow();
      t_buttons();
      t_remote();
      t_recal();
      summarize();
   end
endmodule : prt_totaliser_tb
